/* rtl/point_table_cfg.svh */
`ifndef POINT_TABLE_CFG_SVH
`define POINT_TABLE_CFG_SVH
// register offsets (byte addresses on the plain port)
`define REG_CTRL          8'h00
`define REG_JOG_SPEED     8'h04
`define REG_JOG_ACCEL     8'h08
`define REG_JOG_DECEL     8'h0C
`define REG_HALT_DECEL    8'h10
`define REG_INDEX_DECEL   8'h14
`define REG_LIMIT_A       8'h18
`define REG_LIMIT_B       8'h1C
`define REG_POINT_BASE    8'h20
`define REG_POINT_CTRL    8'h24
`define REG_ACT_POS       8'h28
`define REG_TARGET_POS    8'h2C
`define REG_STATUS        8'h30
`define REG_WARN_NUM      8'h34
`define REG_CMD_POS       8'h38
// control register fields
`define CTRL_LEVEL_BIT    0
`define CTRL_PT0_EN_BIT   1
`define CTRL_SOFTLIM_BIT  2
`define CTRL_PT_MODE_BIT  3
// point table entry: bits 31:2 signed target position, mode in [1:0]
`define PT_MODE_ABS       2'b00
// reset values
`define RST_INDEX_DECEL   32'h0000_0064
`define RST_LIMIT         32'h7735_9400
`define RST_JOG_SPEED     32'h0000_0010
`define RST_JOG_ACCEL     32'h0000_0001
`define RST_JOG_DECEL     32'h0000_0001
`define RST_HALT_DECEL    32'h0000_0004
`define RST_CTRL          32'h0000_0008
// warning numbers
`define WARN_NONE         8'h00
`define WARN_SOFT_FWD     8'hD7
`define WARN_SOFT_REV     8'hD8
// timing: motion update tick period
`define TICK_US           1
`define CLK_MHZ           20
`define TICK_CYCLES       (`TICK_US * `CLK_MHZ)
`endif

/* rtl/point_table_pkg.sv */
`default_nettype none
package point_table_pkg;
	// motion state of the axis
	typedef enum logic [2:0] {
		MOT_IDLE,
		MOT_POINT,
		MOT_JOG,
		MOT_HALT,
		MOT_LIMIT
	} motion_t;
	// entry attribute
	typedef logic [1:0] pt_mode_t;
endpackage
`default_nettype wire

/* rtl/point_table_trigger.sv */
// Added by the designer: the placing of the registers and the address-and-strobe port.
`include "point_table_cfg.svh"
`default_nettype none
module point_table_trigger
	import point_table_pkg::*;
#(
	parameter int POINTS = 32,
	parameter int SEL_W  = 5
) (
	// clock and reset
	input  wire logic                 clk_sys,
	input  wire logic                 rst_b,
	// register port
	input  wire logic [7:0]           reg_addr,
	input  wire logic [31:0]          reg_wdata,
	input  wire logic                 reg_wr,
	input  wire logic                 reg_rd,
	output logic      [31:0]          reg_rdata,
	// digital inputs from the controller
	input  wire logic [SEL_W-1:0]     point_select,
	input  wire logic                 point_trigger_n,
	input  wire logic                 jog_forward_n,
	input  wire logic                 jog_reverse_n,
	input  wire logic                 halt_n,
	input  wire logic                 forward_overtravel,
	input  wire logic                 reverse_overtravel,
	// position feedback
	input  wire logic signed [31:0]   actual_position_monitor,
	// outputs
	output logic                      soft_limit_output,
	output logic      [2:0]           in_place_code,
	output logic                      motion_busy,
	output logic signed [31:0]        position_command
);
	import point_table_pkg::*;

	localparam int TICK_N = `TICK_CYCLES;

	// input synchronisers, bit order: sel, trig, jf, jr, halt, pot, not
	localparam int IN_W = SEL_W + 6;
	logic [IN_W-1:0] in_meta_q;        // first stage
	logic [IN_W-1:0] in_sync_q;        // second stage
	logic            trig_prev_q;      // trigger history for edge
	logic [SEL_W-1:0] sel_s;
	logic            trig_s, jf_s, jr_s, halt_s, pot_s, not_s;

	// settings
	logic [31:0]        ctrl_q;
	logic [31:0]        jog_speed_setting, jog_accel_setting, jog_decel_setting;
	logic [31:0]        halt_decel_setting, index_decel_time;
	logic signed [31:0] limit_position_a, limit_position_b;
	logic               soft_limit_enable_bit; // latched once after reset
	logic               soft_en_taken_q;
	logic [31:0]        point_mem [POINTS];    // per point target and mode
	logic [4:0]         pt_widx;               // point written via port

	// motion state
	motion_t            state_q;
	logic signed [31:0] speed_q;               // signed pulses per tick
	logic signed [31:0] target_q;
	logic [SEL_W-1:0]   cur_point_q;
	logic               jog_dir_q;             // 1 = forward
	logic [7:0]         warn_q;
	logic [1:0]         ot_block_q;            // [1]=forward block, [0]=reverse
	logic [$clog2(TICK_N+1)-1:0] tick_cnt_q;
	logic               tick;

	// synchroniser chain
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			in_meta_q   <= '1;
			in_sync_q   <= '1;
			trig_prev_q <= 1'b1;
		end else begin
			in_meta_q   <= {point_select, point_trigger_n, jog_forward_n,
				jog_reverse_n, halt_n, ~forward_overtravel, ~reverse_overtravel};
			in_sync_q   <= in_meta_q;
			trig_prev_q <= trig_s;
		end
	end

	// decode synced inputs
	always_comb begin
		sel_s  = in_sync_q[IN_W-1 -: SEL_W];
		trig_s = in_sync_q[5];
		jf_s   = ~in_sync_q[4];
		jr_s   = ~in_sync_q[3];
		halt_s = ~in_sync_q[2];
		pot_s  = ~in_sync_q[1];
		not_s  = ~in_sync_q[0];
	end

	// motion update tick divider
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			tick_cnt_q <= '0;
			tick       <= 1'b0;
		end else if (tick_cnt_q == ($bits(tick_cnt_q))'(TICK_N - 1)) begin
			tick_cnt_q <= '0;
			tick       <= 1'b1;
		end else begin
			tick_cnt_q <= tick_cnt_q + 1'b1;
			tick       <= 1'b0;
		end
	end

	// settings registers; limits act at once, index decel time is only stored and read back
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			ctrl_q             <= `RST_CTRL;
			jog_speed_setting  <= `RST_JOG_SPEED;
			jog_accel_setting  <= `RST_JOG_ACCEL;
			jog_decel_setting  <= `RST_JOG_DECEL;
			halt_decel_setting <= `RST_HALT_DECEL;
			index_decel_time   <= `RST_INDEX_DECEL;
			limit_position_a   <= `RST_LIMIT;
			limit_position_b   <= `RST_LIMIT;
			pt_widx            <= '0;
		end else if (reg_wr) begin
			case (reg_addr)
				`REG_CTRL:        ctrl_q             <= reg_wdata;
				`REG_JOG_SPEED:   jog_speed_setting  <= reg_wdata;
				`REG_JOG_ACCEL:   jog_accel_setting  <= reg_wdata;
				`REG_JOG_DECEL:   jog_decel_setting  <= reg_wdata;
				`REG_HALT_DECEL:  halt_decel_setting <= reg_wdata;
				`REG_INDEX_DECEL: index_decel_time   <= reg_wdata;
				`REG_LIMIT_A:     limit_position_a   <= reg_wdata;
				`REG_LIMIT_B:     limit_position_b   <= reg_wdata;
				`REG_POINT_BASE:  pt_widx            <= reg_wdata[4:0];
				default: begin
				end
			endcase
		end
	end

	// point table storage
	always_ff @(posedge clk_sys) begin
		if (reg_wr && reg_addr == `REG_POINT_CTRL) begin
			point_mem[pt_widx] <= reg_wdata;
		end
	end

	// soft limit enable caught once after reset release
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			soft_limit_enable_bit <= 1'b0;
			soft_en_taken_q       <= 1'b0;
		end else if (!soft_en_taken_q) begin
			soft_limit_enable_bit <= (reg_wr && reg_addr == `REG_CTRL)
				? reg_wdata[`CTRL_SOFTLIM_BIT] : ctrl_q[`CTRL_SOFTLIM_BIT];
			soft_en_taken_q       <= reg_wr && reg_addr == `REG_CTRL;
		end
	end

	// range with swap when first below second
	logic signed [31:0] lim_hi, lim_lo;
	logic               above_range, below_range;
	always_comb begin
		if (limit_position_a < limit_position_b) begin
			lim_hi = limit_position_b;
			lim_lo = limit_position_a;
		end else begin
			lim_hi = limit_position_a;
			lim_lo = limit_position_b;
		end
		above_range = soft_limit_enable_bit && (actual_position_monitor > lim_hi);
		below_range = soft_limit_enable_bit && (actual_position_monitor < lim_lo);
	end

	// trigger decode
	logic        pt_mode;
	logic        level_mode;
	logic        trig_fall;
	logic [31:0] sel_entry;
	logic        point_ok;
	logic        start_point, start_jog;
	logic        jog_fwd_req;
	logic signed [31:0] pt_target, next_pos; // entry target, command after this tick
	always_comb begin
		pt_mode     = ctrl_q[`CTRL_PT_MODE_BIT];
		level_mode  = ctrl_q[`CTRL_LEVEL_BIT];
		trig_fall   = trig_prev_q && !trig_s;
		sel_entry   = point_mem[sel_s];
		pt_target   = {{2{sel_entry[31]}}, sel_entry[31:2]};
		next_pos    = position_command + speed_q;
		// point 0 gated by its enable
		point_ok    = (sel_s != '0) || ctrl_q[`CTRL_PT0_EN_BIT];
		// level mode: only absolute entries
		if (level_mode) begin
			start_point = !trig_s && point_ok
				&& sel_entry[1:0] == `PT_MODE_ABS;
		end else begin
			start_point = trig_fall && point_ok;
		end
		// forward jog takes priority when both pressed
		jog_fwd_req = jf_s;
		start_jog   = (jf_s || jr_s) && (!level_mode || trig_s);
	end

	// main motion sequencer
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			state_q     <= MOT_IDLE;
			speed_q     <= '0;
			target_q    <= '0;
			cur_point_q <= '0;
			jog_dir_q   <= 1'b0;
			warn_q      <= `WARN_NONE;
			ot_block_q  <= 2'b00;
		end else if (pt_mode && halt_s && state_q != MOT_IDLE
				&& state_q != MOT_HALT) begin
			state_q <= MOT_HALT;
		end else begin
			case (state_q)
				MOT_IDLE: begin
					// soft range check; motor stays energised
					if (above_range) begin
						warn_q <= `WARN_SOFT_FWD;
					end else if (below_range) begin
						warn_q <= `WARN_SOFT_REV;
					end
					if (pt_mode && start_point) begin
						// command away from the blocked side releases limit
						if ((pt_target < position_command
								|| (!ot_block_q[1] && warn_q != `WARN_SOFT_FWD))
								&& (pt_target > position_command
								|| (!ot_block_q[0] && warn_q != `WARN_SOFT_REV))) begin
							state_q     <= MOT_POINT;
							target_q    <= pt_target;
							cur_point_q <= sel_s;
							warn_q      <= `WARN_NONE;
							ot_block_q  <= 2'b00;
						end
					end else if (pt_mode && start_jog) begin
						// jog away from a limit stays allowed
						if (jog_fwd_req ? !ot_block_q[1] : !ot_block_q[0]) begin
							state_q    <= MOT_JOG;
							jog_dir_q  <= jog_fwd_req;
							warn_q     <= `WARN_NONE;
							ot_block_q <= 2'b00;
						end
					end
				end
				MOT_POINT: begin
					// overtravel aborts, target follows command
					if ((pot_s && speed_q > 0) || (not_s && speed_q < 0)) begin
						state_q    <= MOT_LIMIT;
						ot_block_q <= {pot_s, not_s};
						target_q   <= position_command;
					end else if (above_range || below_range) begin
						state_q <= MOT_LIMIT;
						warn_q  <= above_range ? `WARN_SOFT_FWD : `WARN_SOFT_REV;
					end else if (tick) begin
						if (next_pos == target_q) begin // stop as the last step lands
							state_q <= MOT_IDLE;
							speed_q <= '0;
						end else if (target_q > next_pos) begin
							speed_q <= 32'sd1;
						end else begin
							speed_q <= -32'sd1;
						end
					end
				end
				MOT_JOG: begin
					// trapezoid: accel to speed, decel on release
					if ((jog_dir_q && pot_s) || (!jog_dir_q && not_s)) begin
						state_q    <= MOT_LIMIT;
						ot_block_q <= {pot_s, not_s};
					end else if (above_range || below_range) begin
						state_q <= MOT_LIMIT;
						warn_q  <= above_range ? `WARN_SOFT_FWD : `WARN_SOFT_REV;
					end else if (tick) begin
						if (jog_dir_q ? jf_s : jr_s) begin
							if ((speed_q < 0 ? -speed_q : speed_q)
									< $signed(jog_speed_setting)) begin
								speed_q <= jog_dir_q ? speed_q + $signed(jog_accel_setting)
									: speed_q - $signed(jog_accel_setting);
							end
						end else if ((speed_q < 0 ? -speed_q : speed_q)
								<= $signed(jog_decel_setting)) begin
							speed_q <= '0;
							state_q <= MOT_IDLE;
						end else begin
							speed_q <= jog_dir_q ? speed_q - $signed(jog_decel_setting)
								: speed_q + $signed(jog_decel_setting);
						end
					end
				end
				MOT_HALT: begin
					// ramp to zero with halt decel
					if (tick) begin
						if ((speed_q < 0 ? -speed_q : speed_q)
								<= $signed(halt_decel_setting)) begin
							// speed and point cleared, target set to command, no resume
							speed_q     <= '0;
							state_q     <= MOT_IDLE;
							cur_point_q <= '0;
							target_q    <= position_command;
						end else begin
							speed_q <= (speed_q > 0) ? speed_q - $signed(halt_decel_setting)
								: speed_q + $signed(halt_decel_setting);
						end
					end
				end
				MOT_LIMIT: begin
					// stopped at a limit, wait for a fresh command
					speed_q     <= '0;
					cur_point_q <= '0;
					state_q     <= MOT_IDLE;
				end
				default: state_q <= MOT_IDLE;
			endcase
		end
	end

	// position integrator
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			position_command <= '0;
		end else if (tick) begin
			position_command <= position_command + speed_q;
		end
	end

	// outputs from flops
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			soft_limit_output <= 1'b0;
			in_place_code     <= 3'b000;
			motion_busy       <= 1'b0;
		end else begin
			soft_limit_output <= warn_q != `WARN_NONE;
			in_place_code     <= (state_q == MOT_IDLE && cur_point_q != '0
				&& cur_point_q < 5'd8 && position_command == target_q)
				? cur_point_q[2:0] : 3'b000;
			motion_busy       <= state_q != MOT_IDLE;
		end
	end

	// register read, data one cycle later
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			reg_rdata <= '0;
		end else if (reg_rd) begin
			case (reg_addr)
				`REG_CTRL:        reg_rdata <= ctrl_q;
				`REG_JOG_SPEED:   reg_rdata <= jog_speed_setting;
				`REG_JOG_ACCEL:   reg_rdata <= jog_accel_setting;
				`REG_JOG_DECEL:   reg_rdata <= jog_decel_setting;
				`REG_HALT_DECEL:  reg_rdata <= halt_decel_setting;
				`REG_INDEX_DECEL: reg_rdata <= index_decel_time;
				`REG_LIMIT_A:     reg_rdata <= limit_position_a;
				`REG_LIMIT_B:     reg_rdata <= limit_position_b;
				`REG_ACT_POS:     reg_rdata <= actual_position_monitor;
				`REG_TARGET_POS:  reg_rdata <= (state_q == MOT_POINT) ? target_q
					: position_command;
				`REG_STATUS:      reg_rdata <= {24'h0000_00, 1'b0, state_q, ot_block_q,
					soft_limit_enable_bit, 1'b0} ;
				`REG_WARN_NUM:    reg_rdata <= {24'h0000_00, warn_q};
				`REG_CMD_POS:     reg_rdata <= position_command;
				default:          reg_rdata <= '0;
			endcase
		end else begin
			reg_rdata <= '0;
		end
	end
endmodule
`default_nettype wire

/* test/point_table_checker.sv */
`default_nettype none
module point_table_checker (
	// clock and reset
	input  wire logic               clk_sys,
	input  wire logic               rst_b,
	// register read side
	input  wire logic               reg_rd,
	input  wire logic [31:0]        reg_rdata,
	// controller io
	input  wire logic               halt_n,
	input  wire logic               forward_overtravel,
	input  wire logic               jog_forward_n,
	input  wire logic               jog_reverse_n,
	// drive outputs
	input  wire logic               soft_limit_output,
	input  wire logic [2:0]         in_place_code,
	input  wire logic               motion_busy,
	input  wire logic signed [31:0] position_command
);
	timeunit 1ns;
	timeprecision 1ns;
	// one domain: shared clock and reset
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_b);
	// halt low long enough to clear the sync flops
	sequence halt_held;
		!halt_n [*4];
	endsequence
	// both jog pins released
	sequence jog_idle;
		jog_forward_n && jog_reverse_n;
	endsequence
	chk_rdata_quiet_slot: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
		else $error("read data not zero outside read slot");
	chk_place_when_still: assert property (in_place_code != 3'h0 |-> !motion_busy || $rose(motion_busy))
		else $error("in-place code while moving");
	chk_halt_stops_axis: assert property (halt_held |-> ##[0:1000] !motion_busy)
		else $error("halt did not bring axis to rest");
	chk_halt_no_start: assert property (halt_held |-> !$rose(motion_busy))
		else $error("motion started under halt");
	chk_overtravel_abort: assert property ($rose(forward_overtravel) ##0 jog_idle |-> ##[1:1000] !motion_busy)
		else $error("point motion not aborted on overtravel");
	chk_idle_hold_pos: assert property (!motion_busy && !$past(motion_busy) |-> $stable(position_command))
		else $error("command moved while idle");
	chk_tick_step_gap: assert property ($changed(position_command) |=> $stable(position_command) [*8])
		else $error("command stepped faster than the tick");
	chk_soft_limit_stop: assert property ($rose(soft_limit_output) |-> ##[0:1000] !motion_busy)
		else $error("motion kept running in soft limit");
endmodule
bind point_table_trigger point_table_checker u_chk (
	.clk_sys(clk_sys), .rst_b(rst_b), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.halt_n(halt_n), .forward_overtravel(forward_overtravel),
	.jog_forward_n(jog_forward_n), .jog_reverse_n(jog_reverse_n),
	.soft_limit_output(soft_limit_output), .in_place_code(in_place_code),
	.motion_busy(motion_busy), .position_command(position_command)
);
`default_nettype wire

/* test/io_host.sv */
`default_nettype none
module io_host (
	// clock
	input  wire logic       clk_sys,
	// lines toward the drive
	output logic [4:0]      point_select,
	output logic            point_trigger_n,
	output logic            jog_forward_n,
	output logic            jog_reverse_n,
	output logic            halt_n
);
	timeunit 1ns;
	timeprecision 1ns;
	// active-low lines rest released
	initial begin
		point_select    = 5'h00;
		point_trigger_n = 1'b1;
		jog_forward_n   = 1'b1;
		jog_reverse_n   = 1'b1;
		halt_n          = 1'b1;
	end
	// select first, trigger once the select has settled
	task automatic fire(input logic [4:0] sel, input int hold);
		@(posedge clk_sys);
		point_select <= sel;
		repeat (4) @(posedge clk_sys);
		point_trigger_n <= 1'b0;
		repeat (hold) @(posedge clk_sys);
		point_trigger_n <= 1'b1;
	endtask
	// jog one way for n cycles
	task automatic jog(input logic fwd, input int n);
		@(posedge clk_sys);
		jog_forward_n <= !fwd;
		jog_reverse_n <= fwd;
		repeat (n) @(posedge clk_sys);
		jog_forward_n <= 1'b1;
		jog_reverse_n <= 1'b1;
	endtask
	// halt line low for n cycles
	task automatic stop(input int n);
		@(posedge clk_sys);
		halt_n <= 1'b0;
		repeat (n) @(posedge clk_sys);
		halt_n <= 1'b1;
	endtask
endmodule
`default_nettype wire

/* test/tb_point_table_trigger.sv */
`include "point_table_cfg.svh"
`default_nettype none
module tb_point_table_trigger;
	timeunit 1ns;
	timeprecision 1ns;
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin fail_count++; \
	$display("ERROR %s exp %0h got %0h", n, e, g); end end
	// register row: optional write, then read and expect
	typedef struct {logic [7:0] a; logic w; logic [31:0] d; logic [31:0] e;} row_t;
	logic               clk_sys = 1'b0;
	logic               rst_b = 1'b0;
	logic [7:0]         reg_addr = 8'h00;
	logic [31:0]        reg_wdata = 32'h0000_0000;
	logic               reg_wr = 1'b0;
	logic               reg_rd = 1'b0;
	logic [31:0]        reg_rdata;
	wire logic [4:0]    point_select;
	wire logic          point_trigger_n, jog_forward_n, jog_reverse_n, halt_n;
	logic               fwd_ot = 1'b0;
	logic               rev_ot = 1'b0;
	logic signed [31:0] act_pos = 32'sd0;
	logic               soft_limit_output, motion_busy;
	logic [2:0]         in_place_code;
	logic signed [31:0] position_command;
	int                 fail_count = 0;
	int                 total_checks = 0;
	// reset values, unmapped place, then a write and rewrite
	row_t rows [8] = '{
		'{`REG_CTRL, 0, 0, `RST_CTRL}, '{`REG_INDEX_DECEL, 0, 0, 32'h0000_0064},
		'{`REG_LIMIT_A, 0, 0, 32'h7735_9400}, '{`REG_LIMIT_B, 0, 0, 32'h7735_9400},
		'{`REG_WARN_NUM, 0, 0, 32'h0000_0000}, '{8'hFC, 1, 32'h0000_1234, 32'h0000_0000},
		'{`REG_INDEX_DECEL, 1, 32'h0000_2710, 32'h0000_2710},
		'{`REG_INDEX_DECEL, 1, 32'h0000_0064, 32'h0000_0064}};
	// free-running system clock
	always #25 clk_sys = ~clk_sys;
	io_host host (.clk_sys(clk_sys), .point_select(point_select),
		.point_trigger_n(point_trigger_n), .jog_forward_n(jog_forward_n),
		.jog_reverse_n(jog_reverse_n), .halt_n(halt_n));
	point_table_trigger dut (.clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.point_select(point_select), .point_trigger_n(point_trigger_n),
		.jog_forward_n(jog_forward_n), .jog_reverse_n(jog_reverse_n), .halt_n(halt_n),
		.forward_overtravel(fwd_ot), .reverse_overtravel(rev_ot),
		.actual_position_monitor(act_pos), .soft_limit_output(soft_limit_output),
		.in_place_code(in_place_code), .motion_busy(motion_busy),
		.position_command(position_command));
	// one-cycle write strobe
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask
	// one-cycle read strobe, data in the following cycle
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask
	// table entry: target in the upper bits, mode below
	task automatic set_point(input logic [7:0] i, input logic [29:0] t, input logic [1:0] m);
		wr(`REG_POINT_BASE, {24'h0, i});
		wr(`REG_POINT_CTRL, {t, m});
	endtask
	// bounded wait for the axis to come to rest
	task automatic wait_idle(input int lim);
		int n;
		repeat (8) @(posedge clk_sys);
		for (n = 0; n < lim && motion_busy !== 1'b0; n++) @(posedge clk_sys);
		`CHK("busy", 1'b0, motion_busy)
	endtask
	task automatic note(input string s);
		$display("done %s", s);
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	// hang guard
	initial begin
		repeat (90000) @(posedge clk_sys);
		fail_count++;
		$display("ERROR watchdog exp done got hang");
		complete_run();
	end
	initial begin
		logic [31:0]        v;
		logic signed [31:0] p;
		repeat (12) @(posedge clk_sys);
		rst_b <= 1'b1;
		foreach (rows[i]) begin
			if (rows[i].w) wr(rows[i].a, rows[i].d);
			rd(rows[i].a, v);
			`CHK("reg", rows[i].e, v)
		end
		note("registers");
		set_point(0, 30'd12, `PT_MODE_ABS);
		set_point(3, 30'd20, `PT_MODE_ABS);
		set_point(5, 30'd60, `PT_MODE_ABS);
		set_point(2, 30'd0, `PT_MODE_ABS);
		set_point(4, 30'h0FFF_FFFF, `PT_MODE_ABS);
		set_point(6, 30'd500, 2'b01);
		host.fire(5'd0, 6);
		repeat (60) @(posedge clk_sys);
		`CHK("p0 off", 1'b0, motion_busy)
		host.fire(5'd3, 6);
		wait_idle(2000);
		`CHK("pos", 32'sd20, position_command)
		`CHK("place", 3'h3, in_place_code)
		host.fire(5'd5, 6);
		repeat (100) @(posedge clk_sys);
		host.jog(1'b1, 100);
		wait_idle(2000);
		`CHK("pos", 32'sd60, position_command)
		`CHK("place", 3'h5, in_place_code)
		note("points");
		fork
			host.jog(1'b1, 600);
			begin
				repeat (200) @(posedge clk_sys);
				host.fire(5'd2, 6);
			end
		join
		wait_idle(2000);
		`CHK("place", 3'h0, in_place_code)
		`CHK("jog moved", 1'b1, position_command > 32'sd60)
		note("jog");
		host.fire(5'd4, 6);
		repeat (300) @(posedge clk_sys);
		fork
			host.stop(1200);
		join_none
		wait_idle(1000);
		p = position_command;
		wait (halt_n === 1'b1);
		repeat (100) @(posedge clk_sys);
		`CHK("no resume", 1'b0, motion_busy)
		`CHK("halt pos", p, position_command)
		note("halt");
		host.fire(5'd4, 6);
		repeat (200) @(posedge clk_sys);
		fwd_ot <= 1'b1;
		wait_idle(1000);
		rd(`REG_TARGET_POS, v);
		`CHK("target", position_command, v)
		host.fire(5'd2, 6);
		wait_idle(40000);
		`CHK("pos", 32'sd0, position_command)
		fwd_ot <= 1'b0;
		note("overtravel");
		// negative target, stopped by the reverse limit switch
		set_point(7, 30'h3FFF_FFE2, `PT_MODE_ABS);
		host.fire(5'd7, 6);
		repeat (200) @(posedge clk_sys);
		rev_ot <= 1'b1;
		wait_idle(1000);
		p = position_command;
		host.fire(5'd7, 6);
		repeat (60) @(posedge clk_sys);
		`CHK("rev refused", 1'b0, motion_busy)
		host.jog(1'b0, 60);
		`CHK("rev jog", p, position_command)
		host.jog(1'b1, 60);
		wait_idle(2000);
		`CHK("jog away", 1'b1, position_command > p)
		rev_ot <= 1'b0;
		host.fire(5'd2, 6);
		wait_idle(2000);
		`CHK("pos", 32'sd0, position_command)
		`CHK("place", 3'h2, in_place_code)
		note("reverse overtravel");
		// range first: limits set to -100 and 100, so only positions beyond them are flagged
		wr(`REG_LIMIT_A, 32'hFFFF_FF9C);
		wr(`REG_LIMIT_B, 32'h0000_0064);
		wr(`REG_CTRL, 32'h0000_000E);
		host.fire(5'd0, 6);
		wait_idle(2000);
		`CHK("pos", 32'sd12, position_command)
		act_pos <= 32'sd150;
		repeat (10) @(posedge clk_sys);
		`CHK("soft out", 1'b1, soft_limit_output)
		rd(`REG_WARN_NUM, v);
		`CHK("warn", 32'h0000_00D7, v)
		act_pos <= 32'sd50;
		host.jog(1'b0, 60);
		repeat (10) @(posedge clk_sys);
		`CHK("soft out", 1'b0, soft_limit_output)
		wait_idle(2000);
		act_pos <= -32'sd150;
		repeat (10) @(posedge clk_sys);
		rd(`REG_WARN_NUM, v);
		`CHK("warn", 32'h0000_00D8, v)
		note("soft limit");
		act_pos <= 32'sd0;
		wr(`REG_CTRL, 32'h0000_000B);
		rd(`REG_STATUS, v);
		`CHK("soft frozen", 1'b1, v[1])
		host.fire(5'd6, 200);
		`CHK("rel level", 1'b0, motion_busy)
		host.fire(5'd3, 3000);
		wait_idle(4000);
		`CHK("pos", 32'sd20, position_command)
		note("level");
		complete_run();
	end
endmodule
`default_nettype wire
